// >>> rtl/ctr_consts.svh
`ifndef CTR_CONSTS_SVH
`define CTR_CONSTS_SVH

`define CTR_ADDR_W 8
`define CTR_ADDR_CFG 8'h04
`define CTR_ADDR_STAT 8'h08
`define CTR_ADDR_CLR 8'h0C
`define CTR_ADDR_CTL 8'h10
`define CTR_ADDR_MASK 8'h14

`define CTR_CFG_RESET 32'h2022BB7F
`define CTR_CFG_WMASK 32'hB7FFFFFF
`define CTR_CFG_POL 31
`define CTR_CFG_SEL_HI 29
`define CTR_CFG_SEL_LO 28
`define CTR_CFG_PSC_HI 26
`define CTR_CFG_PSC_LO 24
`define CTR_CFG_LIM_HI 23
`define CTR_CFG_LIM_LO 16
`define CTR_CFG_RLD_HI 15
`define CTR_CFG_RLD_LO 0

`define CTR_STAT_CAP_LO 16
`define CTR_STAT_DIR 15
`define CTR_STAT_TERR 10
`define CTR_STAT_MISS 9
`define CTR_STAT_SLOW 8
`define CTR_STAT_ERRF 2
`define CTR_STAT_FLAGS 32'h00000704
`define CTR_STAT_RESET 32'h00000000

`define CTR_CTL_TRIM_COUNTER_ENABLE 5
`define CTR_CTL_ERROR_IRQ_ENABLE 2
`define CTR_CTL_WMASK 32'h00000024
`define CTR_CTL_RESET 32'h00000000
`define CTR_CLR_ERR 2
`define CTR_MASK_RESET 32'h00000000

`define CTR_LIM_SHIFT 7

`endif

// >>> rtl/ctr_pkg.sv
package ctr_pkg;

  typedef enum logic [1:0] {
    CTR_SRC_PIN = 2'b00,
    CTR_SRC_XTAL = 2'b01,
    CTR_SRC_RSV2 = 2'b10,
    CTR_SRC_RSV3 = 2'b11
  } ctr_src_t;

  typedef enum logic [1:0] {
    CTR_RESP_OKAY = 2'b00,
    CTR_RESP_SLVERR = 2'b10,
    CTR_RESP_DECERR = 2'b11
  } ctr_resp_t;

endpackage : ctr_pkg

// >>> rtl/ctr_ref_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ctr_ref_if;
  import ctr_pkg::*;
  logic enable;
  logic polarity;
  ctr_src_t source;
  logic [2:0] prescaler;
  logic sync_pulse;

  modport ctrl (output enable, output polarity, output source,
    output prescaler, input sync_pulse);
  modport shaper (input enable, input polarity, input source,
    input prescaler, output sync_pulse);
endinterface : ctr_ref_if
`default_nettype wire

// >>> rtl/ctr_ref_pulse.sv
`timescale 1ns/10ps
`default_nettype none
module ctr_ref_pulse
  import ctr_pkg::*;
#(
  parameter int PSC_W = 7
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic external_sync_pin,
  input wire logic low_speed_crystal,
  ctr_ref_if.shaper ref_if
);

  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic level;
  logic level_q;
  logic src_ok;
  logic edge_hit;
  logic [PSC_W-1:0] psc_cnt_q;
  logic [PSC_W-1:0] psc_top;
  logic pulse_q;

  // Both sources are resynchronised before selection, so a source switch
  // never feeds a half-settled level into the edge detector.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= (gi == 0) ? external_sync_pin : low_speed_crystal;
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  always_comb
  begin
    unique case (ref_if.source)
      CTR_SRC_PIN:
      begin
        level = sync2_q[0];
        src_ok = 1'b1;
      end
      CTR_SRC_XTAL:
      begin
        level = sync2_q[1];
        src_ok = 1'b1;
      end
      default:
      begin
        level = 1'b0;
        src_ok = 1'b0;
      end
    endcase
  end

  // Inverting the level turns the falling edge into the one detected
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      level_q <= 1'b0;
    else
      level_q <= level ^ ref_if.polarity;
  end

  assign edge_hit = src_ok & ref_if.enable &
    (level ^ ref_if.polarity) & ~level_q;

  assign psc_top = PSC_W'((8'h01 << ref_if.prescaler) - 8'h01);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      psc_cnt_q <= '0;
    else if (!ref_if.enable)
      psc_cnt_q <= '0;
    else if (edge_hit)
      psc_cnt_q <= (psc_cnt_q >= psc_top) ? '0 : psc_cnt_q + 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pulse_q <= 1'b0;
    else
      pulse_q <= edge_hit & (psc_cnt_q >= psc_top);
  end

  assign ref_if.sync_pulse = pulse_q;

endmodule : ctr_ref_pulse
`default_nettype wire

// >>> rtl/ctr_trim_ref.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ctr_consts.svh"
module ctr_trim_ref
  import ctr_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`CTR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CTR_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_sync_pin,
  input wire logic low_speed_crystal,
  input wire logic trim_overflow_event,
  output logic [7:0] base_limit,
  output logic trim_counter_enable,
  output logic error_flag,
  output logic irq
);

  logic [31:0] cfg_q;
  logic [31:0] ctl_q;
  logic [31:0] mask_q;
  logic [CNT_W-1:0] cnt_q;
  logic down_q;
  logic en_q;
  logic [CNT_W-1:0] cap_q;
  logic cap_dir_q;
  logic trim_err_q;
  logic miss_q;
  logic slow_q;
  logic err_flag_q;
  logic irq_q;
  logic aw_held_q;
  logic w_held_q;
  logic [`CTR_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic do_write;
  logic full_word;
  logic wr_cfg;
  logic wr_ctl;
  logic wr_mask;
  logic wr_clr;
  logic wr_stat;
  logic clr_all;
  logic clr_terr;
  logic clr_miss;
  logic clr_slow;
  logic clr_errf;
  logic sync_pulse;
  logic [CNT_W-1:0] lim128;
  logic ev_miss;
  logic ev_slow;
  logic [31:0] stat_word;
  ctr_resp_t wr_resp;

  ctr_ref_if ref_if ();

  assign ref_if.enable = ctl_q[`CTR_CTL_TRIM_COUNTER_ENABLE];
  assign ref_if.polarity = cfg_q[`CTR_CFG_POL];
  assign ref_if.source = ctr_src_t'(cfg_q[`CTR_CFG_SEL_HI:`CTR_CFG_SEL_LO]);
  assign ref_if.prescaler = cfg_q[`CTR_CFG_PSC_HI:`CTR_CFG_PSC_LO];
  assign sync_pulse = ref_if.sync_pulse;

  ctr_ref_pulse #(
    .PSC_W(7)
  ) u_ref_pulse (
    .clk(clk),
    .sys_rst(sys_rst),
    .external_sync_pin(external_sync_pin),
    .low_speed_crystal(low_speed_crystal),
    .ref_if(ref_if.shaper)
  );

  // Write channel: address and data are held separately, either first
  assign s_axi_awready = ~aw_held_q;
  assign s_axi_wready = ~w_held_q;
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (s_axi_awvalid && !aw_held_q)
    begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (s_axi_wvalid && !w_held_q)
    begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_q <= 1'b0;
  end

  assign full_word = (wstrb_q == 4'hF);
  assign wr_cfg = do_write && awaddr_q == `CTR_ADDR_CFG && full_word;
  assign wr_ctl = do_write && awaddr_q == `CTR_ADDR_CTL && full_word;
  assign wr_mask = do_write && awaddr_q == `CTR_ADDR_MASK && full_word;
  assign wr_clr = do_write && awaddr_q == `CTR_ADDR_CLR && full_word;
  assign wr_stat = do_write && awaddr_q == `CTR_ADDR_STAT && full_word;

  always_comb
  begin
    unique case (awaddr_q)
      `CTR_ADDR_CFG, `CTR_ADDR_STAT, `CTR_ADDR_CLR, `CTR_ADDR_CTL,
      `CTR_ADDR_MASK:
        wr_resp = full_word ? CTR_RESP_OKAY : CTR_RESP_SLVERR;
      default:
        wr_resp = CTR_RESP_DECERR;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= CTR_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_resp;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // A blocked write still answers OKAY; software sees it only on read-back
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cfg_q <= `CTR_CFG_RESET;
    else if (wr_cfg && !ctl_q[`CTR_CTL_TRIM_COUNTER_ENABLE])
      cfg_q <= (wdata_q & `CTR_CFG_WMASK) | (cfg_q & ~`CTR_CFG_WMASK);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ctl_q <= `CTR_CTL_RESET;
    else if (wr_ctl)
      ctl_q <= wdata_q & `CTR_CTL_WMASK;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mask_q <= `CTR_MASK_RESET;
    else if (wr_mask)
      mask_q <= wdata_q & `CTR_STAT_FLAGS;
  end

  // Trim counter: reload, count down to zero, then count up
  assign lim128 = {1'b0, cfg_q[`CTR_CFG_LIM_HI:`CTR_CFG_LIM_LO],
    7'h00};

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      en_q <= 1'b0;
    else
      en_q <= ctl_q[`CTR_CTL_TRIM_COUNTER_ENABLE];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
      down_q <= 1'b0;
    end
    else if (ctl_q[`CTR_CTL_TRIM_COUNTER_ENABLE])
    begin
      if (sync_pulse || !en_q)
      begin
        cnt_q <= cfg_q[`CTR_CFG_RLD_HI:`CTR_CFG_RLD_LO];
        down_q <= 1'b1;
      end
      else if (down_q)
      begin
        if (cnt_q == '0)
          down_q <= 1'b0;
        else
          cnt_q <= cnt_q - 1'b1;
      end
      else if (cnt_q != '1)
        cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cap_q <= '0;
    else if (sync_pulse)
      cap_q <= cnt_q;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cap_dir_q <= 1'b0;
    else if (sync_pulse && en_q)
      cap_dir_q <= down_q;
  end

  assign ev_miss = en_q && ctl_q[`CTR_CTL_TRIM_COUNTER_ENABLE] && !down_q &&
    !sync_pulse && cnt_q == lim128;
  assign ev_slow = en_q && sync_pulse && down_q && cnt_q >= lim128;

  // Flags: a new event in the clearing cycle wins over the clear
  assign clr_all = wr_clr && wdata_q[`CTR_CLR_ERR];
  assign clr_terr = clr_all | (wr_stat & wdata_q[`CTR_STAT_TERR]);
  assign clr_miss = clr_all | (wr_stat & wdata_q[`CTR_STAT_MISS]);
  assign clr_slow = clr_all | (wr_stat & wdata_q[`CTR_STAT_SLOW]);
  assign clr_errf = clr_all | (wr_stat & wdata_q[`CTR_STAT_ERRF]);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      trim_err_q <= 1'b0;
    else
      trim_err_q <= trim_overflow_event | (trim_err_q & ~clr_terr);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      miss_q <= 1'b0;
    else
      miss_q <= ev_miss | (miss_q & ~clr_miss);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      slow_q <= 1'b0;
    else
      slow_q <= ev_slow | (slow_q & ~clr_slow);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      err_flag_q <= 1'b0;
    else
      err_flag_q <= trim_overflow_event | ev_miss | ev_slow |
        (err_flag_q & ~clr_errf);
  end

  assign stat_word = {cap_q, cap_dir_q, 4'h0, trim_err_q, miss_q, slow_q,
    5'h00, err_flag_q, 2'h0};

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_q <= 1'b0;
    else
      irq_q <= ctl_q[`CTR_CTL_ERROR_IRQ_ENABLE] &
        (|(stat_word & mask_q & `CTR_STAT_FLAGS));
  end

  // Read channel: one outstanding read, data registered at acceptance
  assign s_axi_arready = ~rvalid_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= CTR_RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= CTR_RESP_OKAY;
      unique case (s_axi_araddr)
        `CTR_ADDR_CFG: rdata_q <= cfg_q;
        `CTR_ADDR_STAT: rdata_q <= stat_word;
        `CTR_ADDR_CLR: rdata_q <= '0;
        `CTR_ADDR_CTL: rdata_q <= ctl_q;
        `CTR_ADDR_MASK: rdata_q <= mask_q;
        default:
        begin
          rdata_q <= '0;
          rresp_q <= CTR_RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  assign base_limit = cfg_q[`CTR_CFG_LIM_HI:`CTR_CFG_LIM_LO];
  assign trim_counter_enable = ctl_q[`CTR_CTL_TRIM_COUNTER_ENABLE];
  assign error_flag = err_flag_q;
  assign irq = irq_q;

endmodule : ctr_trim_ref
`default_nettype wire

// >>> testbench/ctr_trim_ref_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ctr_trim_ref_monitor
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trim_overflow_event,
  input wire logic [7:0] base_limit,
  input wire logic trim_counter_enable,
  input wire logic error_flag,
  input wire logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  rd_after_ar_a: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready)) else $error("stray rvalid");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read address taken without answer");
  ovf_flag_a: assert property (
    trim_overflow_event |-> ##[1:2] error_flag) else $error("no error flag");
  flag_sticky_a: assert property (
    error_flag && s_axi_awready && !s_axi_awvalid |=> error_flag)
    else $error("error flag lost without clear");
  irq_cause_a: assert property (irq |-> $past(error_flag))
    else $error("irq without error flag");
  cfg_lock_a: assert property (
    trim_counter_enable |=> $stable(base_limit))
    else $error("config changed while counting");
endmodule : ctr_trim_ref_monitor

bind ctr_trim_ref ctr_trim_ref_monitor u_ctr_trim_ref_monitor (.clk,
  .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .trim_overflow_event, .base_limit,
  .trim_counter_enable, .error_flag, .irq);
`default_nettype wire

// >>> testbench/ctr_ref_src.sv
`timescale 1ns/10ps
`default_nettype none
module ctr_ref_src
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic line,
  input wire logic [9:0] count,
  output logic external_sync_pin,
  output logic low_speed_crystal,
  output logic busy
);
  // Lines stand still between frames; each level lasts 4 clocks
  logic [9:0] left_q;
  logic [1:0] div_q;
  logic line_q;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      busy <= 1'b0;
      div_q <= 2'h0;
      left_q <= 10'h000;
      line_q <= 1'b0;
      external_sync_pin <= 1'b0;
      low_speed_crystal <= 1'b0;
    end
    else if (go)
    begin
      busy <= 1'b1;
      div_q <= 2'h0;
      left_q <= count;
      line_q <= line;
    end
    else if (busy)
    begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3)
      begin
        left_q <= left_q - 10'h001;
        busy <= (left_q != 10'h001);
        if (line_q)
          low_speed_crystal <= ~low_speed_crystal;
        else
          external_sync_pin <= ~external_sync_pin;
      end
    end
endmodule : ctr_ref_src
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctr_consts.svh"
module tb
  import ctr_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, ovf = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, go = 1'b0, line = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic [9:0] count = 10'h000;
  logic awready, wready, bvalid, arready, rvalid, pin, xtal, busy;
  logic [1:0] bresp, rresp;
  logic [7:0] base_limit;
  logic trim_counter_enable, error_flag, irq;
  int bad_count = 0, n_compared = 0, cyc = 0;

  ctr_trim_ref u_ctr_trim_ref (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .external_sync_pin(pin),
    .low_speed_crystal(xtal), .trim_overflow_event(ovf),
    .base_limit(base_limit), .trim_counter_enable(trim_counter_enable),
    .error_flag(error_flag), .irq(irq));
  ctr_ref_src u_ctr_ref_src (.clk(clk), .sys_rst(sys_rst), .go(go),
    .line(line), .count(count), .external_sync_pin(pin),
    .low_speed_crystal(xtal), .busy(busy));

  always #4 clk = ~clk;

  task automatic tally_and_finish;
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, got);
    n_compared++;
    if (got !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [3:0] s, input ctr_resp_t er);
    logic aw_done, w_done;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      aw_done |= awvalid & awready;
      w_done |= wvalid & wready;
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end
    // Late bready lets the response be seen waiting
    repeat (2) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input ctr_resp_t er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    repeat (2) @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd

  task automatic edges(input logic l, input int n);
    @(posedge clk);
    line <= l;
    count <= 10'(n);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (busy);
  endtask : edges

  task automatic kick;
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : kick

  // Limit 0 makes every pulse while down-counting a slow-clock error
  task automatic rcase(input logic [7:0] top, input logic l, input int n,
    input logic e);
    wr(`CTR_ADDR_CTL, 32'h0, 4'hF, CTR_RESP_OKAY);
    if (pin) edges(1'b0, 1);
    if (xtal) edges(1'b1, 1);
    wr(`CTR_ADDR_CFG, {top, 8'h00, 16'hFFFF}, 4'hF, CTR_RESP_OKAY);
    wr(`CTR_ADDR_CLR, 32'h4, 4'hF, CTR_RESP_OKAY);
    wr(`CTR_ADDR_CTL, 32'h20, 4'hF, CTR_RESP_OKAY);
    edges(l, n);
    repeat (12) @(posedge clk);
    chk("error_flag", {31'h0, e}, {31'h0, error_flag});
    rd(`CTR_ADDR_STAT, CTR_RESP_OKAY);
    chk("slow_clock", {31'h0, e}, {31'h0, d[8]});
    if (e) chk("direction", 1, {31'h0, d[15]});
    if (e) chk("capture", 1, d[31:16] > 16'(65475 - 4 * n));
  endtask : rcase

  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    chk("base_limit_rst", 32'h22, {24'h0, base_limit});
    rd(`CTR_ADDR_CFG, CTR_RESP_OKAY);
    chk("cfg_rst", `CTR_CFG_RESET, d);
    rd(`CTR_ADDR_STAT, CTR_RESP_OKAY);
    chk("stat_rst", 32'h0, d);
    wr(`CTR_ADDR_CFG, 32'hFFFFFFFF, 4'hF, CTR_RESP_OKAY);
    rd(`CTR_ADDR_CFG, CTR_RESP_OKAY);
    chk("cfg_rsvd", 32'hB7FFFFFF, d);
    chk("base_limit", 32'hFF, {24'h0, base_limit});
    wr(`CTR_ADDR_CFG, 32'h0, 4'h3, CTR_RESP_SLVERR);
    rd(`CTR_ADDR_CFG, CTR_RESP_OKAY);
    chk("cfg_narrow", 32'hB7FFFFFF, d);
    rd(8'h40, CTR_RESP_DECERR);
    chk("unmapped", 32'h0, d);
    wr(8'h40, 32'h0, 4'hF, CTR_RESP_DECERR);
    wr(`CTR_ADDR_CTL, 32'h20, 4'hF, CTR_RESP_OKAY);
    chk("enable", 32'h1, {31'h0, trim_counter_enable});
    wr(`CTR_ADDR_CFG, 32'h0, 4'hF, CTR_RESP_OKAY);
    rd(`CTR_ADDR_CFG, CTR_RESP_OKAY);
    chk("cfg_locked", 32'hB7FFFFFF, d);
    wr(`CTR_ADDR_CTL, 32'h04, 4'hF, CTR_RESP_OKAY);
    wr(`CTR_ADDR_MASK, 32'h404, 4'hF, CTR_RESP_OKAY);
    kick();
    chk("irq_on", 32'h1, {31'h0, irq});
    rd(`CTR_ADDR_STAT, CTR_RESP_OKAY);
    chk("stat_trim", 32'h404, d);
    wr(`CTR_ADDR_CLR, 32'h4, 4'hF, CTR_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq_off", 32'h0, {31'h0, irq});
    rd(`CTR_ADDR_STAT, CTR_RESP_OKAY);
    chk("stat_clr", 32'h0, d);
    wr(`CTR_ADDR_MASK, 32'h0, 4'hF, CTR_RESP_OKAY);
    kick();
    chk("irq_masked", 32'h0, {31'h0, irq});
    chk("flag_masked", 32'h1, {31'h0, error_flag});
    wr(`CTR_ADDR_STAT, 32'h404, 4'hF, CTR_RESP_OKAY);
    chk("flag_w1c", 32'h0, {31'h0, error_flag});
    rcase(8'h00, 1'b0, 1, 1'b1);
    rcase(8'h80, 1'b0, 1, 1'b0);
    rcase(8'h80, 1'b0, 2, 1'b1);
    rcase(8'h10, 1'b1, 2, 1'b1);
    rcase(8'h00, 1'b1, 2, 1'b0);
    rcase(8'h20, 1'b0, 2, 1'b0);
    rcase(8'h30, 1'b1, 2, 1'b0);
    rcase(8'h01, 1'b0, 2, 1'b0);
    rcase(8'h01, 1'b0, 4, 1'b1);
    rcase(8'h07, 1'b0, 254, 1'b0);
    rcase(8'h07, 1'b0, 256, 1'b1);
    wr(`CTR_ADDR_CTL, 32'h0, 4'hF, CTR_RESP_OKAY);
    wr(`CTR_ADDR_CFG, 32'h00010010, 4'hF, CTR_RESP_OKAY);
    wr(`CTR_ADDR_CLR, 32'h4, 4'hF, CTR_RESP_OKAY);
    wr(`CTR_ADDR_CTL, 32'h20, 4'hF, CTR_RESP_OKAY);
    repeat (120) @(posedge clk);
    chk("miss_early", 32'h0, {31'h0, error_flag});
    repeat (60) @(posedge clk);
    chk("miss_set", 32'h1, {31'h0, error_flag});
    rd(`CTR_ADDR_STAT, CTR_RESP_OKAY);
    chk("miss_bits", 32'h204, d & `CTR_STAT_FLAGS);
    // Counter is past the limit and counting up when this edge lands
    edges(1'b0, 1);
    repeat (8) @(posedge clk);
    rd(`CTR_ADDR_STAT, CTR_RESP_OKAY);
    chk("direction_up", 32'h0, {31'h0, d[15]});
    chk("slow_up", 32'h0, {31'h0, d[8]});
    chk("capture_up", 1, {31'h0, d[31:16] > 16'h0080});
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
